// [tcc_cfg.svh]
// register offsets, bit positions, reset values and divider ratios of the capture/compare unit
// assumes a byte-wide register port with a 5-bit address
`ifndef TCC_CFG_SVH
`define TCC_CFG_SVH

`define TCC_ADDR_W 5
`define TCC_CTRL1 5'h00
`define TCC_CTRL2 5'h01
`define TCC_STATUS 5'h02
`define TCC_CAP1_HI 5'h03
`define TCC_CAP1_LO 5'h04
`define TCC_CMP1_HI 5'h05
`define TCC_CMP1_LO 5'h06
`define TCC_CNT_HI 5'h07
`define TCC_CNT_LO 5'h08
`define TCC_CAP2_HI 5'h0B
`define TCC_CAP2_LO 5'h0C
`define TCC_CMP2_HI 5'h0D
`define TCC_CMP2_LO 5'h0E

// control register one
`define TCC_C1_CAP_IRQ_EN 7
`define TCC_C1_CMP_IRQ_EN 6
`define TCC_C1_FORCE2 4
`define TCC_C1_FORCE1 3
`define TCC_C1_LEVEL2 2
`define TCC_C1_EDGE1 1
`define TCC_C1_LEVEL1 0
// control register two
`define TCC_C2_OE1 7
`define TCC_C2_OE2 6
`define TCC_C2_SINGLE_PULSE 5
`define TCC_C2_PWM 4
`define TCC_C2_CLK_HI 3
`define TCC_C2_CLK_LO 2
`define TCC_C2_EDGE2 1
`define TCC_C2_EXT_EDGE 0
// status register
`define TCC_ST_CAP1 7
`define TCC_ST_CMP1 6
`define TCC_ST_CAP2 4
`define TCC_ST_CMP2 3

`define TCC_CNT_RESET 16'hFFFC
`define TCC_CMP_RESET 16'h8000
`define TCC_CTRL_RESET 8'h00
// prescaler masks: tick when the masked prescaler bits are all ones
`define TCC_DIV2_MASK 3'h1
`define TCC_DIV4_MASK 3'h3
`define TCC_DIV8_MASK 3'h7

`endif

// [tcc_pkg.sv]
// types shared by the capture/compare unit
// assumes tcc_cfg.svh carries all numeric constants
package tcc_pkg;
	typedef enum logic [1:0] {
		TCC_CLK_DIV4 = 2'b00,
		TCC_CLK_DIV2 = 2'b01,
		TCC_CLK_DIV8 = 2'b10,
		TCC_CLK_EXT = 2'b11
	} tcc_clk_sel_t;
	typedef logic [15:0] tcc_word_t;
endpackage

// [tcc_unit.sv]
// two capture and two compare channels on a 16-bit free-running up-counter
// assumes synchronous pin inputs and a byte register port with read data one cycle later
//
// What this block does
// R1: each capture channel copies the 16-bit counter on its selected pin edge
// R2: capture edge chosen by edge bit in control one (ch1) and control two (ch2)
// R3: capture sets flag; interrupt when capture enable set and global mask clear
// R4: capture flag clears by status read while set, then low byte access
// R5: high byte read blocks captures and flag until low byte is read
// R6: capture register always holds the latest capture, overwriting older values
// R7: in single-pulse or PWM mode only capture channel two captures
// R8: capture pins always connected; selected edge captures unless high-read blocked or channel one in R7 modes
// R9: both 16-bit compare values compared with the counter every timer cycle
// R10: compare values software read/write only, reset to 8000h
// R11: match sets compare flag and drives enabled pin to output level bit
// R12: compare pin latch forced low during reset
// R13: match requests interrupt when compare enable set and global mask clear
// R14: compare flag clears by status read while set, then low byte access
// R15: high byte write suspends compares until the low byte is written
// R16: output enable clear releases pin to port use; flag and interrupt still work
// R17: flag and pin take effect while counter equals compare value, all modes
// R18: force bit copies level to enabled pin, no flag, no interrupt
// R19: force bits ignored in single-pulse and PWM modes
// R20: software writes high byte, reads status, then writes low byte
// R21: timer clock is cpu clock divided by 2, 4 or 8 via clock bits
// R22: single-pulse mode bit sits in control two, uses channel one
// R23: counter counts up, resets to FFFCh, restarts on low byte write
// R24: both clock bits set select external clock on its chosen edge
// R25: both channels evaluated independently in the same cycle
//
// Design decisions made here: the placing of the registers and the strobed register port.
`include "tcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module tcc_unit
	import tcc_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register port
	input wire logic [`TCC_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	output logic [7:0] RD_DATA,
	// pins
	input wire logic [1:0] CAP_IN,
	input wire logic EXT_CLK,
	output logic [1:0] CMP_OUT,
	output logic [1:0] CMP_OE_N,
	// interrupt
	input wire logic IRQ_MASK,
	output logic IRQ
);

	function automatic logic [`TCC_ADDR_W-1:0] cap_hi_addr(input int ch);
		cap_hi_addr = (ch == 0) ? `TCC_CAP1_HI : `TCC_CAP2_HI;
	endfunction
	function automatic logic [`TCC_ADDR_W-1:0] cap_lo_addr(input int ch);
		cap_lo_addr = (ch == 0) ? `TCC_CAP1_LO : `TCC_CAP2_LO;
	endfunction
	function automatic logic [`TCC_ADDR_W-1:0] cmp_hi_addr(input int ch);
		cmp_hi_addr = (ch == 0) ? `TCC_CMP1_HI : `TCC_CMP2_HI;
	endfunction
	function automatic logic [`TCC_ADDR_W-1:0] cmp_lo_addr(input int ch);
		cmp_lo_addr = (ch == 0) ? `TCC_CMP1_LO : `TCC_CMP2_LO;
	endfunction

	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	tcc_word_t cnt_reg;
	logic [2:0] pre_reg;
	logic ext_d_reg;
	logic [7:0] cnt_lo_buf_reg;
	logic cnt_buf_valid_reg;
	tcc_word_t cap_val_reg [2];
	tcc_word_t cmp_val_reg [2];
	logic [1:0] cap_in_d_reg;
	logic [1:0] cap_block_reg;
	logic [1:0] cap_flag_reg;
	logic [1:0] cap_arm_reg;
	logic [1:0] cmp_flag_reg;
	logic [1:0] cmp_arm_reg;
	logic [1:0] cmp_inhibit_reg;
	logic [1:0] cmp_pin_reg;
	logic [1:0] cmp_oe_n_reg;
	logic [7:0] rd_data_reg;
	logic irq_reg;

	// register decode
	wire wr_ctrl1 = WR_EN && (ADDR == `TCC_CTRL1);
	wire wr_ctrl2 = WR_EN && (ADDR == `TCC_CTRL2);
	wire rd_status = RD_EN && (ADDR == `TCC_STATUS);
	wire rd_cnt_hi = RD_EN && (ADDR == `TCC_CNT_HI);
	wire rd_cnt_lo = RD_EN && (ADDR == `TCC_CNT_LO);
	wire wr_cnt_lo = WR_EN && (ADDR == `TCC_CNT_LO);

	// mode decode
	wire single_pulse = ctrl2_reg[`TCC_C2_SINGLE_PULSE]; // [R22]
	wire pwm_mode = ctrl2_reg[`TCC_C2_PWM];
	wire special_mode = single_pulse || pwm_mode;
	wire [1:0] oe = {ctrl2_reg[`TCC_C2_OE2], ctrl2_reg[`TCC_C2_OE1]};
	wire [1:0] level = {ctrl1_reg[`TCC_C1_LEVEL2], ctrl1_reg[`TCC_C1_LEVEL1]};
	wire [1:0] edge_rise = {ctrl2_reg[`TCC_C2_EDGE2], ctrl1_reg[`TCC_C1_EDGE1]};
	wire [1:0] force_req = {WR_DATA[`TCC_C1_FORCE2], WR_DATA[`TCC_C1_FORCE1]};
	wire [1:0] force_hit = (wr_ctrl1 && !special_mode) ? force_req : 2'b00; // [R18] [R19]
	// a forced pin takes the level bit written in the same byte as the force bit
	wire [1:0] force_level = {WR_DATA[`TCC_C1_LEVEL2], WR_DATA[`TCC_C1_LEVEL1]};
	tcc_clk_sel_t clk_sel;
	assign clk_sel = tcc_clk_sel_t'(ctrl2_reg[`TCC_C2_CLK_HI:`TCC_C2_CLK_LO]);

	// timer tick from prescaler or external clock edge
	wire ext_edge = ctrl2_reg[`TCC_C2_EXT_EDGE] ? (EXT_CLK && !ext_d_reg)
		: (!EXT_CLK && ext_d_reg); // [R24]
	wire tick = (clk_sel == TCC_CLK_DIV2) ? ((pre_reg & `TCC_DIV2_MASK) == `TCC_DIV2_MASK)
		: (clk_sel == TCC_CLK_DIV4) ? ((pre_reg & `TCC_DIV4_MASK) == `TCC_DIV4_MASK)
		: (clk_sel == TCC_CLK_DIV8) ? ((pre_reg & `TCC_DIV8_MASK) == `TCC_DIV8_MASK)
		: ext_edge; // [R21] [R24]

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			pre_reg <= 3'h0;
			ext_d_reg <= 1'b0;
		end else begin
			pre_reg <= pre_reg + 3'h1;
			ext_d_reg <= EXT_CLK;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cnt_reg <= `TCC_CNT_RESET;
		end else if (wr_cnt_lo) begin
			cnt_reg <= `TCC_CNT_RESET; // [R23]
		end else if (tick) begin
			cnt_reg <= cnt_reg + 16'h0001; // [R23]
		end
	end

	// counter high read freezes the low byte until the low byte is read
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			cnt_lo_buf_reg <= 8'h00;
			cnt_buf_valid_reg <= 1'b0;
		end else if (rd_cnt_hi) begin
			if (!cnt_buf_valid_reg) begin
				cnt_lo_buf_reg <= cnt_reg[7:0];
			end
			cnt_buf_valid_reg <= 1'b1;
		end else if (rd_cnt_lo) begin
			cnt_buf_valid_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			ctrl1_reg <= `TCC_CTRL_RESET;
			ctrl2_reg <= `TCC_CTRL_RESET;
		end else begin
			if (wr_ctrl1) begin
				// force bits act once and are not stored
				ctrl1_reg <= WR_DATA & 8'hE7;
			end
			if (wr_ctrl2) begin
				ctrl2_reg <= WR_DATA;
			end
		end
	end

	genvar i;
	generate
		for (i = 0; i < 2; i++) begin : g_ch
			wire rd_cap_hi = RD_EN && (ADDR == cap_hi_addr(i));
			wire rd_cap_lo = RD_EN && (ADDR == cap_lo_addr(i));
			wire acc_cap_lo = (RD_EN || WR_EN) && (ADDR == cap_lo_addr(i));
			wire wr_cmp_hi = WR_EN && (ADDR == cmp_hi_addr(i));
			wire wr_cmp_lo = WR_EN && (ADDR == cmp_lo_addr(i));
			wire acc_cmp_lo = (RD_EN || WR_EN) && (ADDR == cmp_lo_addr(i));
			wire pin_rise = CAP_IN[i] && !cap_in_d_reg[i];
			wire pin_fall = !CAP_IN[i] && cap_in_d_reg[i];
			wire pin_edge = edge_rise[i] ? pin_rise : pin_fall; // [R2] [R8]
			wire cap_allow = !cap_block_reg[i] && !((i == 0) && special_mode); // [R5] [R7]
			wire cap_hit = pin_edge && cap_allow; // [R25]
			wire cmp_hit = (cnt_reg == cmp_val_reg[i]) && !cmp_inhibit_reg[i]; // [R9] [R15] [R17]

			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					cap_in_d_reg[i] <= 1'b0;
					cap_val_reg[i] <= 16'h0000;
					cap_block_reg[i] <= 1'b0;
				end else begin
					cap_in_d_reg[i] <= CAP_IN[i];
					if (cap_hit) begin
						cap_val_reg[i] <= cnt_reg; // [R1] [R6]
					end
					if (rd_cap_lo) begin
						cap_block_reg[i] <= 1'b0; // [R5]
					end else if (rd_cap_hi) begin
						cap_block_reg[i] <= 1'b1; // [R5]
					end
				end
			end

			// set wins over clear on both flags
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					cap_flag_reg[i] <= 1'b0;
					cap_arm_reg[i] <= 1'b0;
				end else begin
					if (cap_hit) begin
						cap_flag_reg[i] <= 1'b1; // [R3]
					end else if (acc_cap_lo && cap_arm_reg[i]) begin
						cap_flag_reg[i] <= 1'b0; // [R4]
					end
					if (rd_status) begin
						cap_arm_reg[i] <= cap_flag_reg[i]; // [R4]
					end else if (acc_cap_lo) begin
						cap_arm_reg[i] <= 1'b0;
					end
				end
			end

			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					cmp_val_reg[i] <= `TCC_CMP_RESET; // [R10]
					cmp_inhibit_reg[i] <= 1'b0;
				end else begin
					if (wr_cmp_hi) begin
						cmp_val_reg[i][15:8] <= WR_DATA; // [R10]
						cmp_inhibit_reg[i] <= 1'b1; // [R15]
					end else if (wr_cmp_lo) begin
						cmp_val_reg[i][7:0] <= WR_DATA; // [R10]
						cmp_inhibit_reg[i] <= 1'b0; // [R15]
					end
				end
			end

			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					cmp_flag_reg[i] <= 1'b0;
					cmp_arm_reg[i] <= 1'b0;
				end else begin
					if (cmp_hit) begin
						cmp_flag_reg[i] <= 1'b1; // [R11] [R16] [R25]
					end else if (acc_cmp_lo && cmp_arm_reg[i]) begin
						cmp_flag_reg[i] <= 1'b0; // [R14]
					end
					if (rd_status) begin
						cmp_arm_reg[i] <= cmp_flag_reg[i]; // [R14]
					end else if (acc_cmp_lo) begin
						cmp_arm_reg[i] <= 1'b0;
					end
				end
			end

			// pin latch: low in reset, released to port use when output disabled
			always_ff @(posedge CLK or posedge RST) begin
				if (RST) begin
					cmp_pin_reg[i] <= 1'b0; // [R12]
					cmp_oe_n_reg[i] <= 1'b1;
				end else begin
					cmp_oe_n_reg[i] <= !oe[i]; // [R16]
					if (oe[i] && (cmp_hit || force_hit[i])) begin
						cmp_pin_reg[i] <= force_hit[i] ? force_level[i] : level[i]; // [R11] [R17] [R18]
					end
				end
			end
		end
	endgenerate

	// read data selection
	wire [7:0] status_byte = {cap_flag_reg[0], cmp_flag_reg[0], 2'b00,
		cmp_flag_reg[1], 3'b000} | (cap_flag_reg[1] ? 8'h10 : 8'h00);
	wire [7:0] cnt_lo_byte = cnt_buf_valid_reg ? cnt_lo_buf_reg : cnt_reg[7:0];
	wire [7:0] rd_mux = (ADDR == `TCC_CTRL1) ? ctrl1_reg
		: (ADDR == `TCC_CTRL2) ? ctrl2_reg
		: (ADDR == `TCC_STATUS) ? status_byte
		: (ADDR == `TCC_CAP1_HI) ? cap_val_reg[0][15:8]
		: (ADDR == `TCC_CAP1_LO) ? cap_val_reg[0][7:0]
		: (ADDR == `TCC_CAP2_HI) ? cap_val_reg[1][15:8]
		: (ADDR == `TCC_CAP2_LO) ? cap_val_reg[1][7:0]
		: (ADDR == `TCC_CMP1_HI) ? cmp_val_reg[0][15:8]
		: (ADDR == `TCC_CMP1_LO) ? cmp_val_reg[0][7:0]
		: (ADDR == `TCC_CMP2_HI) ? cmp_val_reg[1][15:8]
		: (ADDR == `TCC_CMP2_LO) ? cmp_val_reg[1][7:0]
		: (ADDR == `TCC_CNT_HI) ? cnt_reg[15:8]
		: (ADDR == `TCC_CNT_LO) ? cnt_lo_byte
		: 8'h00;

	// pending request stays until enable set and global mask clear
	wire irq_next = !IRQ_MASK && (
		((|cap_flag_reg) && ctrl1_reg[`TCC_C1_CAP_IRQ_EN]) || // [R3]
		((|cmp_flag_reg) && ctrl1_reg[`TCC_C1_CMP_IRQ_EN])); // [R13]

	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			rd_data_reg <= 8'h00;
			irq_reg <= 1'b0;
		end else begin
			rd_data_reg <= RD_EN ? rd_mux : 8'h00;
			irq_reg <= irq_next;
		end
	end

	assign RD_DATA = rd_data_reg;
	assign IRQ = irq_reg;
	assign CMP_OUT = cmp_pin_reg;
	assign CMP_OE_N = cmp_oe_n_reg;

endmodule // tcc_unit

`default_nettype wire

// [tcc_unit_chk.sv]
// checker: port assertions for the capture/compare unit
// assumes one CLK domain and the offsets of tcc_cfg.svh
`include "tcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module tcc_unit_chk
	import tcc_pkg::*;
(
	// clock and reset
	input wire logic CLK,
	input wire logic RST,
	// register port
	input wire logic [`TCC_ADDR_W-1:0] ADDR,
	input wire logic [7:0] WR_DATA,
	input wire logic WR_EN,
	input wire logic RD_EN,
	input wire logic [7:0] RD_DATA,
	// pins and interrupt
	input wire logic [1:0] CAP_IN,
	input wire logic EXT_CLK,
	input wire logic [1:0] CMP_OUT,
	input wire logic [1:0] CMP_OE_N,
	input wire logic IRQ_MASK,
	input wire logic IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (RST);
	logic [7:0] c1_reg, c2_reg;
	logic [15:0] v1_reg;
	wire w1 = WR_EN && ADDR == `TCC_CTRL1;
	wire w2 = WR_EN && ADDR == `TCC_CTRL2;
	// shadows of control and compare one, as software wrote them
	always_ff @(posedge CLK or posedge RST) begin
		if (RST) begin
			{c1_reg, c2_reg, v1_reg} <= {16'h0000, `TCC_CMP_RESET};
		end else begin
			if (w1) c1_reg <= WR_DATA;
			if (w2) c2_reg <= WR_DATA;
			if (WR_EN && ADDR == `TCC_CMP1_HI) v1_reg[15:8] <= WR_DATA;
			if (WR_EN && ADDR == `TCC_CMP1_LO) v1_reg[7:0] <= WR_DATA;
		end
	end
	chk_pin_reset: assert property ($fell(RST) |-> CMP_OUT == 2'b00 && CMP_OE_N == 2'b11)
		else $error("compare pins not low after reset");
	chk_oe_follow: assert property (!$past(w2) |-> CMP_OE_N == ~{c2_reg[6], c2_reg[7]})
		else $error("pin enable differs from control");
	chk_irq_masked: assert property (IRQ_MASK |=> !IRQ)
		else $error("interrupt while masked");
	chk_irq_disabled: assert property (!$past(w1) && c1_reg[7:6] == 2'b00 |-> !IRQ)
		else $error("interrupt while disabled");
	chk_irq_pending: assert property (
		IRQ && !IRQ_MASK && !RD_EN && !WR_EN && !$past(RD_EN) && !$past(WR_EN) |=> IRQ)
		else $error("pending interrupt dropped");
	chk_force_level: assert property (
		w1 && WR_DATA[3] && c2_reg[7] && c2_reg[5:4] == 2'b00 |-> ##[1:2] CMP_OUT[0] == c1_reg[0])
		else $error("force did not drive level");
	chk_force_ignored: assert property (
		w1 && WR_DATA[3] && c2_reg[5:4] != 2'b00 |=> $stable(CMP_OUT) [*2])
		else $error("force acted in special mode");
	chk_cmp_readback: assert property (RD_EN && ADDR == `TCC_CMP1_LO |=> RD_DATA == v1_reg[7:0])
		else $error("compare value readback wrong");
	cover property ($rose(IRQ));
	cover property (CMP_OE_N[0] == 1'b0 && CMP_OUT[0]);
	cover property (RD_EN && ADDR == `TCC_CAP2_HI);
endmodule // tcc_unit_chk
bind tcc_unit tcc_unit_chk u_tcc_unit_chk (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA),
	.WR_EN(WR_EN), .RD_EN(RD_EN), .RD_DATA(RD_DATA), .CAP_IN(CAP_IN), .EXT_CLK(EXT_CLK),
	.CMP_OUT(CMP_OUT), .CMP_OE_N(CMP_OE_N), .IRQ_MASK(IRQ_MASK), .IRQ(IRQ));
`default_nettype wire

// [tcc_pins.sv]
// partner: pulse sources on the capture pins and a slow external clock
// assumes flip requests last one cycle and come after a rising edge
`timescale 1ns/1ns
`default_nettype none
module tcc_pins (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// toggle requests
	input wire logic [1:0] flip,
	// pins
	output logic [1:0] cap_pin,
	output logic ext_pin
);
	logic [2:0] div_reg;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cap_pin <= 2'b00;
			div_reg <= 3'h0;
		end else begin
			cap_pin <= cap_pin ^ flip;
			div_reg <= div_reg + 3'h1;
		end
	end
	// period of 8 cycles keeps it under a quarter of the cpu clock
	assign ext_pin = div_reg[2];
endmodule // tcc_pins
`default_nettype wire

// [test_tcc_unit.sv]
// testbench: capture, compare, force and interrupt checks against a model
// assumes tcc_unit, tcc_pins and the checker bound to the unit
`include "tcc_cfg.svh"
`timescale 1ns/1ns
`default_nettype none
module test_tcc_unit
	import tcc_pkg::*;
;
	logic CLK, RST, WR_EN, RD_EN, IRQ_MASK, EXT_CLK, IRQ;
	logic [4:0] ADDR;
	logic [7:0] WR_DATA, RD_DATA, m_c1, m_c2;
	logic [1:0] CAP_IN, CMP_OUT, CMP_OE_N, flip, m_prev, m_blk, s;
	logic [2:0] m_pre, m_msk;
	logic m_ext;
	tcc_word_t m_cnt, t, m_snap;
	tcc_word_t m_cap [2];
	int error_cnt = 0;
	int tests_run = 0;
	int cyc = 0;
	tcc_unit u_tcc_unit (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR_EN(WR_EN),
		.RD_EN(RD_EN), .RD_DATA(RD_DATA), .CAP_IN(CAP_IN), .EXT_CLK(EXT_CLK), .CMP_OUT(CMP_OUT),
		.CMP_OE_N(CMP_OE_N), .IRQ_MASK(IRQ_MASK), .IRQ(IRQ));
	tcc_pins u_tcc_pins (.clk(CLK), .rst(RST), .flip(flip), .cap_pin(CAP_IN), .ext_pin(EXT_CLK));
	initial begin
		CLK = 0;
		forever #25 CLK = ~CLK;
	end
	// model of counter, prescaler and capture registers
	always @(posedge CLK or posedge RST) begin
		if (RST) begin
			{m_pre, m_cnt, m_c1, m_c2, m_prev, m_blk} = {3'h0, `TCC_CNT_RESET, 20'h00000};
			m_cap = '{16'h0000, 16'h0000};
			m_ext = 1'b0;
		end else begin
			for (int i = 0; i < 2; i++)
				if (CAP_IN[i] != m_prev[i] && CAP_IN[i] == (i ? m_c2[1] : m_c1[1]) && !m_blk[i]
					&& !(i == 0 && m_c2[5:4] != 2'b00)) m_cap[i] = m_cnt;
			if (RD_EN && ADDR == `TCC_CAP1_HI) m_blk[0] = 1;
			if (RD_EN && ADDR == `TCC_CAP1_LO) m_blk[0] = 0;
			if (RD_EN && ADDR == `TCC_CAP2_HI) m_blk[1] = 1;
			if (RD_EN && ADDR == `TCC_CAP2_LO) m_blk[1] = 0;
			m_msk = m_c2[3:2] == 2'b01 ? 3'h1 : (m_c2[3:2] == 2'b10 ? 3'h7 : 3'h3);
			if (RD_EN && ADDR == `TCC_CNT_HI) m_snap = m_cnt;
			if (WR_EN && ADDR == `TCC_CNT_LO) m_cnt = `TCC_CNT_RESET;
			else if (m_c2[3:2] == 2'b11 ? (EXT_CLK != m_ext && EXT_CLK == m_c2[0])
				: (m_pre & m_msk) == m_msk) m_cnt++;
			m_ext = EXT_CLK;
			m_pre++;
			m_prev = CAP_IN;
			if (WR_EN && ADDR == `TCC_CTRL1) m_c1 = WR_DATA;
			if (WR_EN && ADDR == `TCC_CTRL2) m_c2 = WR_DATA;
		end
	end
	task chk(input tcc_word_t g, input tcc_word_t e);
		tests_run++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %0t got %h exp %h", $time, g, e);
		end
	endtask
	task wr(input logic [4:0] a, input logic [7:0] d);
		@(posedge CLK);
		{ADDR, WR_DATA, WR_EN} <= {a, d, 1'b1};
		@(posedge CLK);
		WR_EN <= 1'b0;
	endtask
	task rd(input logic [4:0] a, output logic [7:0] d);
		@(posedge CLK);
		{ADDR, RD_EN} <= {a, 1'b1};
		@(posedge CLK);
		RD_EN <= 1'b0;
		@(negedge CLK);
		d = RD_DATA;
	endtask
	task rc(input logic [4:0] a, input tcc_word_t e);
		logic [7:0] h, l;
		rd(a, h);
		rd(a + 5'h01, l);
		chk({h, l}, e);
	endtask
	task rs(input logic [7:0] e);
		logic [7:0] d;
		rd(`TCC_STATUS, d);
		chk(d, e);
	endtask
	task pulse(input logic [1:0] f);
		@(posedge CLK);
		flip <= f;
		@(posedge CLK);
		flip <= 2'b00;
		repeat (3) @(posedge CLK);
	endtask
	task pins(input logic [1:0] o, input logic [1:0] n);
		repeat (3) @(negedge CLK);
		chk(CMP_OUT, o);
		chk(CMP_OE_N, n);
	endtask
	task stop_test();
		$display("checks %0d errors %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			error_cnt++;
			stop_test();
		end
	end
	initial begin
		{RST, WR_EN, RD_EN, IRQ_MASK, ADDR, WR_DATA, flip} = {4'b1001, 15'h0000};
		t = 16'($urandom(33));
		repeat (3) @(posedge CLK);
		RST <= 1'b0;
		rc(`TCC_CMP1_HI, `TCC_CMP_RESET);
		rc(`TCC_CMP2_HI, `TCC_CMP_RESET);
		s = 2'($urandom % 3);
		wr(`TCC_CTRL1, 8'h82);
		wr(`TCC_CTRL2, {4'h0, s, 2'b00});
		repeat (3) pulse(2'b11);
		pins(2'b00, 2'b11);
		chk(IRQ, 16'h0000);
		@(posedge CLK);
		IRQ_MASK <= 1'b0;
		pins(2'b00, 2'b11);
		chk(IRQ, 16'h0001);
		rs(8'h90);
		rc(`TCC_CAP1_HI, m_cap[0]);
		rc(`TCC_CAP2_HI, m_cap[1]);
		rs(8'h00);
		rd(`TCC_CAP2_HI, t[7:0]);
		pulse(2'b10);
		rc(`TCC_CAP2_HI, m_cap[1]);
		rs(8'h00);
		wr(`TCC_CTRL1, 8'h80);
		wr(`TCC_CTRL2, {4'h2, s, 2'b00});
		pulse(2'b01);
		rs(8'h00);
		wr(`TCC_CTRL2, {4'h8, s, 2'b00});
		wr(`TCC_CTRL1, 8'h41);
		t = m_cnt + 16'h000C + 16'($urandom % 8);
		wr(`TCC_CMP1_HI, t[15:8]);
		rs(8'h00);
		wr(`TCC_CMP1_LO, t[7:0]);
		wr(`TCC_CMP2_HI, t[15:8]);
		wr(`TCC_CMP2_LO, t[7:0]);
		for (int i = 0; i < 400 && m_cnt != t + 16'h0002; i++) @(negedge CLK);
		pins(2'b01, 2'b10);
		chk(IRQ, 16'h0001);
		rs(8'h48);
		rc(`TCC_CMP1_HI, t);
		rc(`TCC_CMP2_HI, t);
		rs(8'h00);
		wr(`TCC_CTRL1, 8'h08);
		pins(2'b00, 2'b10);
		rs(8'h00);
		wr(`TCC_CTRL2, {4'h9, s, 2'b00});
		wr(`TCC_CTRL1, 8'h09);
		pins(2'b00, 2'b10);
		wr(`TCC_CTRL2, 8'h0D);
		wr(`TCC_CNT_LO, 8'h00);
		repeat (40) @(posedge CLK);
		rd(`TCC_CNT_HI, t[15:8]);
		rd(`TCC_CNT_LO, t[7:0]);
		chk(t, m_snap);
		@(posedge CLK);
		RST <= 1'b1;
		pins(2'b00, 2'b11);
		@(posedge CLK);
		RST <= 1'b0;
		rc(`TCC_CMP1_HI, `TCC_CMP_RESET);
		stop_test();
	end
endmodule // test_tcc_unit
`default_nettype wire
